// *** include/bst_pkg.sv ***
// boundary-scan tap: shared constants, state and mode types
// assumes one tap per device and a fixed count of scanned pins
package bst_pkg;

  // ---------------------------------------------------------------
  // chain geometry
  // ---------------------------------------------------------------
  localparam int NPIN          = 8;                  // scanned two-way pins
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_OUT      = 0;                  // output data cell
  localparam int CELL_OE       = 1;                  // tri-state control cell
  localparam int CELL_IN       = 2;                  // input capture cell
  localparam int BSR_LEN       = NPIN * CELLS_PER_PIN;

  // ---------------------------------------------------------------
  // instruction register
  // ---------------------------------------------------------------
  localparam int IR_W = 5;
  localparam logic [IR_W-1:0] IR_EXTEST  = 5'h00;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 5'h01;
  localparam logic [IR_W-1:0] IR_INTSCAN = 5'h02;
  localparam logic [IR_W-1:0] IR_CLAMP   = 5'h04;
  localparam logic [IR_W-1:0] IR_HIGHZ   = 5'h05;
  localparam logic [IR_W-1:0] IR_PRIVATE = 5'h09;
  localparam logic [IR_W-1:0] IR_MEMBIST = 5'h0a;
  localparam logic [IR_W-1:0] IR_IDCODE  = 5'h0c;
  localparam logic [IR_W-1:0] IR_BYPASS  = 5'h1f;
  localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;    // fixed capture pattern

  // ---------------------------------------------------------------
  // identification register layout
  // ---------------------------------------------------------------
  localparam int ID_W      = 32;
  localparam int ID_VER_W  = 4;                      // bits 31-28
  localparam int ID_PART_W = 16;                     // bits 27-12
  localparam int ID_MFR_W  = 11;                     // bits 11-1
  localparam logic ID_FIXED_LSB = 1'b1;              // bit 0

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0]
  {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PAU_DR  = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UPD_DR  = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'ha,
    TAP_SH_IR   = 4'hb,
    TAP_EX1_IR  = 4'hc,
    TAP_PAU_IR  = 4'hd,
    TAP_EX2_IR  = 4'he,
    TAP_UPD_IR  = 4'hf
  } bst_tap_e;

  typedef enum logic [1:0]
  {
    DRV_FUNC  = 2'h0,                                // core owns the pins
    DRV_BSR   = 2'h1,                                // pins from update cells
    DRV_HIGHZ = 2'h2                                 // all pin drivers off
  } bst_drive_e;

  typedef enum logic [1:0]
  {
    SEL_BYPASS = 2'h0,
    SEL_BSR    = 2'h1,
    SEL_ID     = 2'h2
  } bst_dr_e;

endpackage

// *** rtl/bst_tap.sv ***
// boundary-scan test access port with bypass, id and boundary chain
// assumes tck from the board tester, core pin signals on ref_clk,
// and a power-on reset pulse on por_n separate from rst_n
//
// Function
// - five tap pins; the eight two-way pad pins scanned, clock and reset pins not
// - sixteen-state controller clocked by tck, steered by tms
// - power-on reset forces test-logic-reset state
// - five-bit instruction picks the data register
// - undefined instruction codes act as bypass
// - extest: chain drives pins, captures pin states
// - sample: capture pins, preload without disturbing
// - highz: bypass selected, all pin drivers off
// - clamp: pins from chain, bypass shifts
// - idcode connects the identification register
// - bypass is one shift stage tdi to tdo
// - id: version, part, maker fields, read-only
// - id bit zero always reads one
// - parallel capture on rising tck
// - chain enters at tdi, leaves at tdo
`timescale 1ns/1ps
`default_nettype none

module bst_tap #(
  parameter logic [bst_pkg::ID_VER_W-1:0]  ID_VERSION = 4'h2,    // arbitrary value
  parameter logic [bst_pkg::ID_PART_W-1:0] ID_PART    = 16'h1234, // arbitrary value
  parameter logic [bst_pkg::ID_MFR_W-1:0]  ID_MFR     = 11'h0a5  // arbitrary value
)
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      por_n,
  input  wire logic                      tck,
  input  wire logic                      trst_n,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdoOe,
  input  wire logic [bst_pkg::NPIN-1:0]  coreOut,
  input  wire logic [bst_pkg::NPIN-1:0]  coreOe,
  output logic      [bst_pkg::NPIN-1:0]  coreIn,
  input  wire logic [bst_pkg::NPIN-1:0]  padIn,
  output logic      [bst_pkg::NPIN-1:0]  padOut,
  output logic      [bst_pkg::NPIN-1:0]  padOe
);
  import bst_pkg::*;

  // ---------------------------------------------------------------
  // state records, one per clock edge family
  // ---------------------------------------------------------------
  typedef struct packed
  {
    bst_tap_e             state;
    logic [IR_W-1:0]      irShift;
    logic [IR_W-1:0]      ir;
    logic                 bypass;
    logic [ID_W-1:0]      idShift;
    logic [BSR_LEN-1:0]   bsrShift;
    logic [BSR_LEN-1:0]   bsrUpd;
    logic [BSR_LEN-1:0]   view1;
    logic [BSR_LEN-1:0]   view2;
    bst_drive_e           drive;
    logic                 updTgl;
    logic                 testLvl;
  } bst_tck_s;

  typedef struct packed
  {
    logic                 tdo;
    logic                 tdoOe;
  } bst_tdo_s;

  typedef struct packed
  {
    logic                 tgl1;
    logic                 tgl2;
    logic                 tgl3;
    logic                 lvl1;
    logic                 lvl2;
    bst_drive_e           drive;
    logic [BSR_LEN-1:0]   bsr;
    logic [NPIN-1:0]      padIn1;
    logic [NPIN-1:0]      padIn2;
    logic [NPIN-1:0]      padOut;
    logic [NPIN-1:0]      padOe;
  } bst_ref_s;

  bst_tck_s             tckSt_ff;
  bst_tck_s             nxt_tckSt;
  bst_tdo_s             tdoSt_ff;
  bst_tdo_s             nxt_tdoSt;
  bst_ref_s             refSt_ff;
  bst_ref_s             nxt_refSt;
  logic                 tapRst_n;
  logic [BSR_LEN-1:0]   pinRaw;
  logic [NPIN-1:0]      bsrDrvOut;
  logic [NPIN-1:0]      bsrDrvOe;
  logic [ID_W-1:0]      idValue;
  bst_dr_e              drSel;
  logic                 testLvl;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // standard tap transition table
  function automatic bst_tap_e tapNext(input bst_tap_e s, input logic m);
    bst_tap_e n;
    n = TAP_RESET;
    case (s)
      TAP_RESET:  n = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  n = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: n = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  n = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: n = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
      default:    n = TAP_RESET;
    endcase
    return n;
  endfunction

  // which data register sits between tdi and tdo
  function automatic bst_dr_e irSelect(input logic [IR_W-1:0] code);
    bst_dr_e d;
    d = SEL_BYPASS;
    case (code)
      IR_EXTEST:  d = SEL_BSR;
      IR_SAMPLE:  d = SEL_BSR;
      IR_IDCODE:  d = SEL_ID;
      IR_HIGHZ:   d = SEL_BYPASS;
      IR_CLAMP:   d = SEL_BYPASS;
      // private, internal-scan and bist codes are decoded only
      IR_INTSCAN: d = SEL_BYPASS;
      IR_PRIVATE: d = SEL_BYPASS;
      IR_MEMBIST: d = SEL_BYPASS;
      default:    d = SEL_BYPASS;
    endcase
    return d;
  endfunction

  // pin ownership implied by an instruction
  function automatic bst_drive_e irDrive(input logic [IR_W-1:0] code);
    bst_drive_e d;
    d = DRV_FUNC;
    case (code)
      IR_EXTEST: d = DRV_BSR;
      IR_CLAMP:  d = DRV_BSR;
      IR_HIGHZ:  d = DRV_HIGHZ;
      default:   d = DRV_FUNC;                       // sample never disturbs
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // tck domain
  // ---------------------------------------------------------------
  // power-on reset and test reset both clear the tap, apart from rst_n
  assign tapRst_n = trst_n & por_n;

  // read-only identity word, lsb hard-wired
  assign idValue = {ID_VERSION, ID_PART, ID_MFR, ID_FIXED_LSB};

  assign drSel = irSelect(tckSt_ff.ir);

  // per-pin cell wiring; test-port pins are not in this vector
  for (genvar g = 0; g < NPIN; g++)
  begin : gCell
    assign pinRaw[g*CELLS_PER_PIN+CELL_OUT] = refSt_ff.padOut[g];
    assign pinRaw[g*CELLS_PER_PIN+CELL_OE]  = refSt_ff.padOe[g];
    assign pinRaw[g*CELLS_PER_PIN+CELL_IN]  = padIn[g];
    assign bsrDrvOut[g] = refSt_ff.bsr[g*CELLS_PER_PIN+CELL_OUT];
    assign bsrDrvOe[g]  = refSt_ff.bsr[g*CELLS_PER_PIN+CELL_OE];
  end

  // controller, shift paths and update stages
  always_comb
  begin
    nxt_tckSt       = tckSt_ff;
    nxt_tckSt.state = tapNext(tckSt_ff.state, tms);
    // pins and driver values are async to tck, so synchronise first
    nxt_tckSt.view1 = pinRaw;
    nxt_tckSt.view2 = tckSt_ff.view1;
    case (tckSt_ff.state)
      TAP_RESET:
      begin
        nxt_tckSt.ir    = IR_IDCODE;
        nxt_tckSt.drive = DRV_FUNC;
        nxt_tckSt.testLvl = 1'b0;
      end
      TAP_CAP_IR:
      begin
        nxt_tckSt.irShift = IR_CAPTURE;
      end
      TAP_SH_IR:
      begin
        nxt_tckSt.irShift = {tdi, tckSt_ff.irShift[IR_W-1:1]};
      end
      TAP_UPD_IR:
      begin
        nxt_tckSt.ir     = tckSt_ff.irShift;
        nxt_tckSt.drive  = irDrive(tckSt_ff.irShift);
        nxt_tckSt.testLvl = (irDrive(tckSt_ff.irShift) != DRV_FUNC);
        nxt_tckSt.updTgl = ~tckSt_ff.updTgl;
      end
      TAP_CAP_DR:
      begin
        nxt_tckSt.bypass  = 1'b0;
        nxt_tckSt.idShift = idValue;
        if (drSel == SEL_BSR)
        begin
          nxt_tckSt.bsrShift = tckSt_ff.view2;
        end
      end
      TAP_SH_DR:
      begin
        case (drSel)
          SEL_BSR:
          begin
            nxt_tckSt.bsrShift = {tdi, tckSt_ff.bsrShift[BSR_LEN-1:1]};
          end
          SEL_ID:
          begin
            nxt_tckSt.idShift = {tdi, tckSt_ff.idShift[ID_W-1:1]};
          end
          default:
          begin
            nxt_tckSt.bypass = tdi;
          end
        endcase
      end
      TAP_UPD_DR:
      begin
        // preload via sample lands here too, but stays off the pins
        if (drSel == SEL_BSR)
        begin
          nxt_tckSt.bsrUpd = tckSt_ff.bsrShift;
          nxt_tckSt.updTgl = ~tckSt_ff.updTgl;
        end
      end
      default:
      begin
        nxt_tckSt.ir = tckSt_ff.ir;
      end
    endcase
  end

  always_ff @(posedge tck or negedge tapRst_n)
  begin
    if (!tapRst_n)
    begin
      tckSt_ff       <= '0;
      tckSt_ff.state <= TAP_RESET;
      tckSt_ff.ir    <= IR_IDCODE;
      tckSt_ff.drive <= DRV_FUNC;
    end
    else
    begin
      tckSt_ff <= nxt_tckSt;
    end
  end

  // tdo changes on the falling edge so the tester samples it clean
  always_comb
  begin
    nxt_tdoSt       = tdoSt_ff;
    nxt_tdoSt.tdoOe = (tckSt_ff.state == TAP_SH_DR) ||
                      (tckSt_ff.state == TAP_SH_IR);
    if (tckSt_ff.state == TAP_SH_IR)
    begin
      nxt_tdoSt.tdo = tckSt_ff.irShift[0];
    end
    else
    begin
      case (drSel)
        SEL_BSR: nxt_tdoSt.tdo = tckSt_ff.bsrShift[0];
        SEL_ID:  nxt_tdoSt.tdo = tckSt_ff.idShift[0];
        default: nxt_tdoSt.tdo = tckSt_ff.bypass;
      endcase
    end
  end

  always_ff @(negedge tck or negedge tapRst_n)
  begin
    if (!tapRst_n)
    begin
      tdoSt_ff <= '0;
    end
    else
    begin
      tdoSt_ff <= nxt_tdoSt;
    end
  end

  // ---------------------------------------------------------------
  // ref_clk domain: pin drivers
  // ---------------------------------------------------------------
  // one level says a test mode is live; a toggle says the held
  // update word and mode are stable and may be copied across
  assign testLvl = tckSt_ff.testLvl;                 // a flop, so no decode glitch reaches the synchroniser

  always_comb
  begin
    nxt_refSt        = refSt_ff;
    nxt_refSt.tgl1   = tckSt_ff.updTgl;
    nxt_refSt.tgl2   = refSt_ff.tgl1;
    nxt_refSt.tgl3   = refSt_ff.tgl2;
    nxt_refSt.lvl1   = testLvl;
    nxt_refSt.lvl2   = refSt_ff.lvl1;
    nxt_refSt.padIn1 = padIn;
    nxt_refSt.padIn2 = refSt_ff.padIn1;
    // tck side holds both words for several tck periods after a toggle
    if (refSt_ff.tgl2 != refSt_ff.tgl3)
    begin
      nxt_refSt.bsr   = tckSt_ff.bsrUpd;
      nxt_refSt.drive = tckSt_ff.drive;
    end
    // pins go back to the core as soon as the level drops
    if (refSt_ff.lvl2 && (refSt_ff.drive == DRV_BSR))
    begin
      nxt_refSt.padOut = bsrDrvOut;
      nxt_refSt.padOe  = bsrDrvOe;
    end
    else if (refSt_ff.lvl2 && (refSt_ff.drive == DRV_HIGHZ))
    begin
      nxt_refSt.padOut = coreOut;
      nxt_refSt.padOe  = '0;
    end
    else
    begin
      nxt_refSt.padOut = coreOut;
      nxt_refSt.padOe  = coreOe;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refSt_ff       <= '0;
      refSt_ff.drive <= DRV_FUNC;
    end
    else
    begin
      refSt_ff <= nxt_refSt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign tdo    = tdoSt_ff.tdo;
  assign tdoOe  = tdoSt_ff.tdoOe;
  assign coreIn = refSt_ff.padIn2;
  assign padOut = refSt_ff.padOut;
  assign padOe  = refSt_ff.padOe;

endmodule

`default_nettype wire

// *** tb/bst_jtag_model.sv ***
// board tester model driving the test access port
// assumes the bench calls its tasks; test clock parks low between frames
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_model
(
  output logic     tck,
  output logic     trst_n,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo
);
  // parked: clock low, test reset released
  initial
  begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 80 ns test clock; lines set while low, tdo taken at the rise
  task automatic pulse(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #20 tck = 1'b1;
    q = tdo;
    #40 tck = 1'b0;
    #20;
  endtask
  // idle, select, capture, shift n bits lsb first, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    #7; // keeps test clock edges off the core clock edges
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q); // two idle clocks let pin synchronisers settle
    pulse(1'b1, 1'b0, q);
    if (ir)
      pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask
  task automatic ir(input logic [4:0] c, output logic [4:0] cap);
    logic [31:0] d;
    scan(1'b1, 5, {27'h0, c}, d);
    cap = d[4:0];
  endtask
  task automatic dr(input logic [31:0] din, output logic [31:0] dout);
    scan(1'b0, 32, din, dout);
  endtask
  // test reset held over one clock; kept high during every scan
  task automatic trstPulse();
    logic q;
    trst_n = 1'b0;
    pulse(1'b1, 1'b0, q);
    #120 trst_n = 1'b1;
  endtask
  task automatic walkReset();
    logic q;
    repeat (5) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask
endmodule
`default_nettype wire

// *** tb/bst_tap_props.sv ***
// checker for the tap block, watching its top-level ports only
// assumes it is bound onto bst_tap from the bench top
`timescale 1ns/1ps
`default_nettype none
module bst_tap_props
(
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     por_n,
  input wire logic                     tck,
  input wire logic                     trst_n,
  input wire logic                     tms,
  input wire logic                     tdi,
  input wire logic                     tdo,
  input wire logic                     tdoOe,
  input wire logic [bst_pkg::NPIN-1:0] coreOut,
  input wire logic [bst_pkg::NPIN-1:0] coreOe,
  input wire logic [bst_pkg::NPIN-1:0] coreIn,
  input wire logic [bst_pkg::NPIN-1:0] padIn,
  input wire logic [bst_pkg::NPIN-1:0] padOut,
  input wire logic [bst_pkg::NPIN-1:0] padOe
);
  import bst_pkg::*;
  // ----
  // helpers
  // ----
  wire        tapRstN = trst_n & por_n;
  logic [1:0] refAge_ff;
  // masks the first edges after core reset, flops still hold reset values
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      refAge_ff <= 2'h0;
    else if (refAge_ff != 2'h3)
      refAge_ff <= refAge_ff + 2'h1;
  // walk from idle into shift-ir, and the five-ones reset walk
  sequence irPath;
    !tms ##1 tms ##1 tms ##1 !tms ##1 !tms;
  endsequence
  sequence resetWalk;
    tms [*5] ##1 !tms;
  endsequence
  // ----
  // test clock domain
  // ----
  ir_capture_a: assert property (@(posedge tck) disable iff (!tapRstN)
    irPath ##1 $rose(tdoOe) |-> tdo ##1 (!tdoOe || !tdo)) else $error("ir capture pattern wrong");
  reset_walk_a: assert property (@(posedge tck) disable iff (!tapRstN)
    resetWalk |=> !tdoOe) else $error("five ones did not park the controller");
  shift_entry_a: assert property (@(posedge tck) disable iff (!tapRstN)
    $rose(tdoOe) |-> !$past(tms) && ($past(tms, 2) != $past(tms, 3)))
    else $error("shift entered on wrong path");
  shift_hold_a: assert property (@(posedge tck) disable iff (!tapRstN)
    tdoOe |=> (tdoOe == !$past(tms))) else $error("output enable not tied to shift state");
  // ----
  // core clock domain
  // ----
  tap_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !tapRstN ##1 !tapRstN |-> !tdoOe && !tdo) else $error("serial out active in test reset");
  core_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    refAge_ff == 2'h3 |-> coreIn == $past(padIn, 2)) else $error("core input path disturbed");
  func_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (refAge_ff == 2'h3 && !trst_n) [*6] |-> padOut == $past(coreOut) && padOe == $past(coreOe))
    else $error("pins not back with the core");
  tdo_falling_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tck && $past(tck) && tapRstN && $past(tapRstN) |-> $stable(tdo) && $stable(tdoOe))
    else $error("serial out moved while test clock high");
endmodule
`default_nettype wire

// *** tb/tb_bst_tap.sv ***
// bench top for the tap block: core clock, tester model, scenarios
// assumes the checker is bound below and the tester model drives the link
`timescale 1ns/1ps
`default_nettype none
module tb_bst_tap;
  import bst_pkg::*;
  localparam logic [3:0]  VER    = 4'h7;    // arbitrary value
  localparam logic [15:0] PART   = 16'hbeef; // arbitrary value
  localparam logic [10:0] MFR    = 11'h15a; // arbitrary value
  localparam logic [31:0] ID_EXP = {VER, PART, MFR, 1'b1};
  localparam logic [7:0]  C_OUT  = 8'h5a;
  localparam logic [7:0]  C_OE   = 8'hc3;
  localparam logic [7:0]  P_IN   = 8'h96;
  logic            ref_clk = 1'b0;
  logic            rst_n, por_n, tck, trst_n, tms, tdi, tdo, tdoOe;
  logic [NPIN-1:0] coreOut, coreOe, coreIn, padIn, padOut, padOe;
  int              n_fail = 0;
  int              cmp_count = 0;
  int              cycCnt = 0;
  always #10 ref_clk = ~ref_clk;
  bst_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) bst_tap_inst
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .coreOut(coreOut), .coreOe(coreOe), .coreIn(coreIn),
    .padIn(padIn), .padOut(padOut), .padOe(padOe)
  );
  bst_jtag_model bst_jtag_model_inst
  (
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo)
  );
  // ----
  // shared helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // chain word from pin values, three cells per pin
  function automatic logic [23:0] cells(input logic [7:0] o, input logic [7:0] e, input logic [7:0] p);
    for (int k = 0; k < 8; k++)
      cells[k*3 +: 3] = {p[k], e[k], o[k]};
  endfunction
  task automatic ir(input logic [4:0] c);
    logic [4:0] cap;
    bst_jtag_model_inst.ir(c, cap);
    check(cap, 32'h1);
    repeat (12) @(posedge ref_clk); // pins settle after the crossing
  endtask
  // 32 shifts; a 24-cell chain keeps the upper 24 bits shifted in
  task automatic dr(input logic [31:0] din, output logic [31:0] dout);
    bst_jtag_model_inst.dr(din, dout);
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic viaBypass();
    logic [31:0] d;
    dr(32'hc0de1235, d);
    check(d, 32'h81bc246a);
  endtask
  // ----
  // scenarios
  // ----
  task automatic idRead();
    logic [31:0] d;
    dr(32'h0, d);
    check(d, ID_EXP);
    check({padOe, padOut}, {C_OE, C_OUT});
    check(coreIn, P_IN);
  endtask
  task automatic bypassCodes();
    logic [4:0] codes [8] = '{5'h1f, 5'h02, 5'h09, 5'h0a, 5'h13, 5'h1e, IR_CLAMP, IR_HIGHZ};
    foreach (codes[k])
    begin
      ir(codes[k]);
      viaBypass();
    end
    check(padOe, 32'h0);
    ir(IR_IDCODE);
    idRead();
  endtask
  task automatic extestLoop();
    logic [31:0] d;
    bst_jtag_model_inst.trstPulse();
    ir(IR_EXTEST);
    check({padOe, padOut}, 32'h0);
    dr({cells(8'ha5, 8'h3c, 8'h00), 8'h00}, d);
    check(d[23:0], cells(8'h00, 8'h00, P_IN));
    check({padOe, padOut}, 32'h3ca5);
    dr(32'h0, d);
    check(d[23:0], cells(8'ha5, 8'h3c, P_IN));
  endtask
  task automatic sampleClamp();
    logic [31:0] d;
    ir(IR_SAMPLE);
    check({padOe, padOut}, {C_OE, C_OUT});
    // core keeps running under sample: pins and core inputs must follow
    padIn   <= ~P_IN;
    coreOut <= ~C_OUT;
    dr({cells(8'h0f, 8'hf0, 8'h00), 8'h00}, d);
    check(d[23:0], cells(~C_OUT, C_OE, ~P_IN));
    check({padOe, padOut, coreIn}, {C_OE, ~C_OUT, ~P_IN});
    padIn   <= P_IN;
    coreOut <= C_OUT;
    ir(IR_CLAMP);
    check({padOe, padOut}, 32'hf00f);
    viaBypass();
  endtask
  // test reset, power-on reset and five-ones walk each restore the id
  task automatic resetPaths();
    logic q;
    ir(IR_HIGHZ);
    check(padOe, 32'h0);
    bst_jtag_model_inst.trstPulse();
    repeat (12) @(posedge ref_clk);
    idRead();
    ir(IR_BYPASS);
    por_n <= 1'b0;
    bst_jtag_model_inst.pulse(1'b0, 1'b0, q);
    @(posedge ref_clk);
    por_n <= 1'b1;
    idRead();
    ir(IR_BYPASS);
    bst_jtag_model_inst.walkReset();
    idRead();
  endtask
  // ----
  // run control
  // ----
  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang is cut well past the few thousand cycles the run needs
  always @(posedge ref_clk)
  begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    por_n = 1'b0;
    coreOut = C_OUT;
    coreOe = C_OE;
    padIn = P_IN;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    idRead();
    bypassCodes();
    extestLoop();
    sampleClamp();
    resetPaths();
    tally_and_finish();
  end
endmodule
bind bst_tap bst_tap_props bst_tap_props_inst
(
  .ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .tck(tck), .trst_n(trst_n), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .coreOut(coreOut), .coreOe(coreOe), .coreIn(coreIn),
  .padIn(padIn), .padOut(padOut), .padOe(padOe)
);
`default_nettype wire
